// ### design/pcgc_global_ctrl.v
// Global enable, overflow status and clear for the performance counters.
`timescale 1ns/1ps
`include "pcgc_map.vh"
// Notes on behaviour
// - Upper four enables valid only when count eight.
// - Setting upper enables with count four faults.
// - Count needs global and privilege enables both.
// - One overflow status bit per counter.
// - Extra status bit flags precise-sampling overflow.
// - Condition-changed flag set on each accepted global-enable write.
// - Overflow arms; next event makes sample.
// - Bounds checked against save area first.
// - Pass: store record, clear status, reload.
// - Fail: skip store; status kept, no reload.
// - Buffer full sets buffer-overflow status flag.
// - One clear-register write clears selected flags.
// - Eight counters; count field reports four or eight.
// - Shared core shows only counters zero to three.
// - Unshared core shows eight at 0C1H-0C8H.
// - Count four faults upper counters, bits 7:4.
// - Capability bit 13 advertises full-width writes.
// - Normal write loads sign-extended low 32 bits.
// - Alias write loads counter at full width.
// - Sample clears only overflowed precise-enabled bits.
module pcgc_global_ctrl #(
  parameter WIDTH = `PCGC_CTR_WIDTH,
  parameter NGEN = `PCGC_GEN_COUNT,
  parameter NFIX = `PCGC_FIX_COUNT
) (
  ref_clk,
  rst_n,
  coreShared,
  regWrite,
  regRead,
  regAddr,
  regWdata,
  privUser,
  genEvent,
  fixEvent,
  preciseEnable,
  reloadValue,
  boundsOk,
  bufferFull,
  regRdata,
  regDone,
  protectionFault,
  recordStore,
  recordCounter,
  counterCount
);
  input wire ref_clk;
  input wire rst_n;
  input wire coreShared;                 // Core shared by two logical processors.
  input wire regWrite;                   // Register write strobe.
  input wire regRead;                    // Register read strobe.
  input wire [11:0] regAddr;             // Register number.
  input wire [63:0] regWdata;            // Write data.
  input wire privUser;                   // Current privilege is user level.
  input wire [NGEN-1:0] genEvent;        // Events for general counters.
  input wire [NFIX-1:0] fixEvent;        // Events for fixed counters.
  input wire [3:0] preciseEnable;        // Precise sampling enable, counters 0-3.
  input wire [WIDTH-1:0] reloadValue;    // Reload value from the save area.
  input wire boundsOk;                   // Save-area bounds check result.
  input wire bufferFull;                 // Sample buffer has filled.
  output reg [63:0] regRdata;
  output reg regDone;                    // Access finished, one cycle.
  output reg protectionFault;            // Access faulted, one cycle.
  output reg recordStore;                // Sample record written, one cycle.
  output reg [1:0] recordCounter;        // Counter that produced the record.
  output reg [7:0] counterCount;         // Reported counter count field.

  // =====================================================
  // Decoding
  // Returns one when the counter privilege bits allow counting now.
  function privOk;
    input usr;
    input os;
    input isUser;
    begin
      privOk = isUser ? usr : os;
    end
  endfunction

  reg [63:0] enable_q;                   // Global enable register.
  reg [63:0] status_q;                   // Global status register.
  reg [63:0] sel_q [0:NGEN-1];           // Event selectors.
  reg [11:0] fixCtrl_q;                  // Fixed counter control.
  reg [1:0] sampleIdx_q;
  reg samplePend_q;
  reg sampleOk_q;
  wire [WIDTH-1:0] genCount [0:NGEN-1];
  wire [NGEN-1:0] genWrap;
  wire [NGEN-1:0] genSample;
  wire [NFIX-1:0] fixWrap;
  wire [WIDTH-1:0] fixCount [0:NFIX-1];
  wire eight;
  wire [63:0] ctrWriteVal;
  wire [63:0] upperMask;
  wire [3:0] clearHit;

  assign eight = ~coreShared;
  assign upperMask = 64'h0000_0000_0000_00F0;
  assign ctrWriteVal = {{32{regWdata[31]}}, regWdata[31:0]};

  // =====================================================
  // Access checks
  reg fault;
  reg known;
  reg [63:0] rd;
  reg [3:0] gIdx;
  integer k;

  // Decodes the register number and checks for faulting accesses.
  always @* begin
    fault = 1'b0;
    known = 1'b1;
    rd = 64'h0;
    gIdx = 4'h0;
    if (regAddr >= `PCGC_ADDR_COUNTER0 && regAddr <= `PCGC_ADDR_COUNTER7) begin
      gIdx = regAddr[3:0] - 4'h1;
      rd = {{(64-WIDTH){1'b0}}, genCount[gIdx[2:0]]};
      fault = !eight && regAddr >= `PCGC_ADDR_COUNTER4;
    end else if (regAddr >= `PCGC_ADDR_ALIAS0 && regAddr < `PCGC_ADDR_ALIAS0 + 12'h008) begin
      gIdx = regAddr[3:0] - 4'h1;
      rd = {{(64-WIDTH){1'b0}}, genCount[gIdx[2:0]]};
      fault = !eight && gIdx[2];
    end else if (regAddr >= `PCGC_ADDR_SELECTOR0 && regAddr < `PCGC_ADDR_SELECTOR0 + 12'h008) begin
      gIdx = regAddr[3:0] - 4'h6;
      rd = sel_q[gIdx[2:0]];
      fault = !eight && gIdx[2];
    end else begin
      case (regAddr)
        `PCGC_ADDR_GLOBAL_ENABLE: begin
          rd = enable_q;
          fault = regWrite && !eight && |(regWdata & upperMask);
        end
        `PCGC_ADDR_GLOBAL_STATUS: begin
          rd = status_q;
          fault = regWrite; // Read-only register.
        end
        `PCGC_ADDR_OVERFLOW_CLEAR: begin
          fault = regRead || (!eight && |(regWdata & upperMask));
        end
        `PCGC_ADDR_FIXED_CTRL: begin
          rd = {52'h0, fixCtrl_q};
        end
        `PCGC_ADDR_CAPABILITIES: begin
          rd = 64'h0000_0000_0000_2000;
          fault = regWrite;
        end
        default: begin
          known = 1'b0;
        end
      endcase
    end
    if (!known) begin
      fault = 1'b1;
    end
  end

  wire wrOk;
  assign wrOk = regWrite && !fault;

  // =====================================================
  // Counters
  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1) begin : genCtr
      wire en;
      wire nrm;
      wire ali;
      assign en = enable_q[g] && sel_q[g][`PCGC_SEL_EN_BIT] &&
        privOk(sel_q[g][`PCGC_SEL_USR_BIT], sel_q[g][`PCGC_SEL_OS_BIT], privUser);
      assign nrm = wrOk && regAddr == `PCGC_ADDR_COUNTER0 + g;
      assign ali = wrOk && regAddr == `PCGC_ADDR_ALIAS0 + g;
      pcgc_counter #(.WIDTH(WIDTH)) u_ctr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .countEn(en),
        .eventIn(genEvent[g]),
        .preciseEn(g < 4 ? preciseEnable[g % 4] : 1'b0),
        .loadEn(nrm | ali),
        .loadVal(ali ? regWdata[WIDTH-1:0] : ctrWriteVal[WIDTH-1:0]),
        .reloadEn(samplePend_q && sampleOk_q && sampleIdx_q == g),
        .reloadVal(reloadValue),
        .count(genCount[g]),
        .wrapPulse(genWrap[g]),
        .sampleReq(genSample[g])
      );
    end
    for (g = 0; g < NFIX; g = g + 1) begin : fixCtr
      wire en;
      assign en = enable_q[`PCGC_FIXED_BASE + g] &&
        privOk(fixCtrl_q[4*g+1], fixCtrl_q[4*g], privUser);
      pcgc_counter #(.WIDTH(WIDTH)) u_ctr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .countEn(en),
        .eventIn(fixEvent[g]),
        .preciseEn(1'b0),
        .loadEn(1'b0),
        .loadVal({WIDTH{1'b0}}),
        .reloadEn(1'b0),
        .reloadVal({WIDTH{1'b0}}),
        .count(fixCount[g]),
        .wrapPulse(fixWrap[g]),
        .sampleReq()
      );
    end
  endgenerate

  // =====================================================
  // Sampling flow
  // Picks the lowest pending sample, checks bounds, stores or skips.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      samplePend_q <= 1'b0;
      sampleOk_q <= 1'b0;
      sampleIdx_q <= 2'h0;
      recordStore <= 1'b0;
      recordCounter <= 2'h0;
    end else begin
      recordStore <= 1'b0;
      samplePend_q <= 1'b0;
      if (samplePend_q && sampleOk_q) begin
        recordStore <= 1'b1;
        recordCounter <= sampleIdx_q;
      end
      // Bounds are checked in the request cycle, before any store.
      if (|genSample[3:0]) begin
        samplePend_q <= 1'b1;
        sampleOk_q <= boundsOk;
        sampleIdx_q <= genSample[0] ? 2'h0 : genSample[1] ? 2'h1 :
          genSample[2] ? 2'h2 : 2'h3;
      end
    end
  end

  assign clearHit = (samplePend_q && sampleOk_q) ?
    (preciseEnable & status_q[3:0]) : 4'h0;

  // =====================================================
  // Registers
  reg [63:0] setBits;
  reg [63:0] clrBits;

  // Gathers status set and clear terms; sets win over clears.
  always @* begin
    setBits = 64'h0;
    clrBits = 64'h0;
    setBits[NGEN-1:0] = genWrap;
    setBits[`PCGC_FIXED_BASE +: NFIX] = fixWrap;
    setBits[`PCGC_BUF_FULL_BIT] = bufferFull;
    setBits[`PCGC_COND_CHG_BIT] = wrOk && regAddr == `PCGC_ADDR_GLOBAL_ENABLE;
    for (k = 0; k < 4; k = k + 1) begin
      setBits[`PCGC_BUF_FULL_BIT - 1] = setBits[`PCGC_BUF_FULL_BIT - 1] |
        (genWrap[k] & preciseEnable[k]);
    end
    clrBits[3:0] = clearHit;
    if (wrOk && regAddr == `PCGC_ADDR_OVERFLOW_CLEAR) begin
      clrBits = clrBits | regWdata;
    end
  end

  // Holds the software registers and answers accesses.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 64'h0;
      status_q <= 64'h0;
      fixCtrl_q <= 12'h0;
      regRdata <= 64'h0;
      regDone <= 1'b0;
      protectionFault <= 1'b0;
      counterCount <= 8'h4;
    end else begin
      counterCount <= eight ? 8'h8 : 8'h4;
      status_q <= (status_q & ~clrBits) | setBits;
      regDone <= (regWrite | regRead) & ~fault;
      protectionFault <= (regWrite | regRead) & fault;
      if (regRead && !fault) begin
        regRdata <= rd;
      end
      if (wrOk && regAddr == `PCGC_ADDR_GLOBAL_ENABLE) begin
        enable_q <= regWdata & {29'h0, {NFIX{1'b1}}, 24'h0, {NGEN{1'b1}}};
      end
      if (wrOk && regAddr == `PCGC_ADDR_FIXED_CTRL) begin
        fixCtrl_q <= regWdata[11:0];
      end
    end
  end

  generate
    for (g = 0; g < NGEN; g = g + 1) begin : selReg
      // Event selector storage.
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sel_q[g] <= 64'h0;
        end else if (wrOk && regAddr == `PCGC_ADDR_SELECTOR0 + g) begin
          sel_q[g] <= regWdata;
        end
      end
    end
  endgenerate
endmodule // pcgc_global_ctrl

// ### design/pcgc_map.vh
// Register numbers, field positions and widths for the counter global control block.
`ifndef PCGC_MAP_VH
`define PCGC_MAP_VH
// Model register numbers (12-bit address space of this block).
`define PCGC_ADDR_COUNTER0 12'h0C1
`define PCGC_ADDR_COUNTER4 12'h0C5
`define PCGC_ADDR_COUNTER7 12'h0C8
`define PCGC_ADDR_SELECTOR0 12'h186
`define PCGC_ADDR_ALIAS0 12'h4C1
`define PCGC_ADDR_CAPABILITIES 12'h345
`define PCGC_ADDR_FIXED_CTRL 12'h38D
`define PCGC_ADDR_GLOBAL_STATUS 12'h38E
`define PCGC_ADDR_GLOBAL_ENABLE 12'h38F
`define PCGC_ADDR_OVERFLOW_CLEAR 12'h390
// Field positions.
`define PCGC_FIXED_BASE 32
`define PCGC_BUF_FULL_BIT 62
`define PCGC_COND_CHG_BIT 63
`define PCGC_FW_WRITE_BIT 13
`define PCGC_SEL_USR_BIT 16
`define PCGC_SEL_OS_BIT 17
`define PCGC_SEL_EN_BIT 22
// Counter width and counter counts.
`define PCGC_CTR_WIDTH 48
`define PCGC_GEN_COUNT 8
`define PCGC_FIX_COUNT 3
`endif

// ### design/pcgc_counter.v
// One counter with enable gating, overflow and precise-sampling arming.
`timescale 1ns/1ps
`include "pcgc_map.vh"
module pcgc_counter #(
  parameter WIDTH = `PCGC_CTR_WIDTH
) (
  ref_clk,
  rst_n,
  countEn,
  eventIn,
  preciseEn,
  loadEn,
  loadVal,
  reloadEn,
  reloadVal,
  count,
  wrapPulse,
  sampleReq
);
  input wire ref_clk;
  input wire rst_n;
  input wire countEn;             // Global AND privilege enable.
  input wire eventIn;             // One event this cycle.
  input wire preciseEn;           // Counter set up for precise sampling.
  input wire loadEn;              // Software load.
  input wire [WIDTH-1:0] loadVal; // Software load value.
  input wire reloadEn;            // Reload after a stored sample.
  input wire [WIDTH-1:0] reloadVal;
  output reg [WIDTH-1:0] count;
  output reg wrapPulse;           // Registered wrap, one cycle.
  output reg sampleReq;           // Registered precise-sampling request, one cycle.

  // =====================================================
  // Counting
  reg armed_q; // Overflow seen; next counted event samples.
  wire step;
  wire wrap;
  assign step = countEn & eventIn;
  assign wrap = step & (&count);

  // Counts events, arms on wrap, raises sample request on the next event.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
      armed_q <= 1'b0;
      wrapPulse <= 1'b0;
      sampleReq <= 1'b0;
    end else begin
      wrapPulse <= wrap;
      sampleReq <= 1'b0;
      if (loadEn) begin
        count <= loadVal;
        armed_q <= 1'b0;
      end else if (reloadEn) begin
        count <= reloadVal;
      end else if (step) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        if (armed_q) begin
          sampleReq <= 1'b1;
          armed_q <= 1'b0;
        end else if (wrap && preciseEn) begin
          armed_q <= 1'b1;
        end
      end
      if (!preciseEn) begin
        armed_q <= 1'b0;
      end
    end
  end
endmodule // pcgc_counter

// ### tb/pcgc_global_ctrl_properties.sv
// Port-level assertions for the counter global control block.
`timescale 1ns/1ps
module pcgc_global_ctrl_properties #(
  parameter WIDTH = 48,
  parameter NGEN = 8,
  parameter NFIX = 3
) (
  input wire ref_clk,
  input wire rst_n,
  input wire coreShared,
  input wire regWrite,
  input wire regRead,
  input wire [11:0] regAddr,
  input wire [63:0] regWdata,
  input wire boundsOk,
  input wire regDone,
  input wire protectionFault,
  input wire recordStore,
  input wire [7:0] counterCount
);
  // ==========================================================
  // Helpers and defaults.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire anyAccess = regWrite | regRead; // Any register access this cycle.
  wire upperCtr = (regAddr >= 12'h0C5) && (regAddr <= 12'h0C8); // Counters four to seven.
  // ==========================================================
  // Access answers, faults, count field and record pulses.
  chk_access_answer: assert property (anyAccess |=> regDone ^ protectionFault)
    else $error("access got no single answer");
  chk_idle_quiet: assert property (!anyAccess |=> !regDone && !protectionFault)
    else $error("answer without access");
  chk_upper_shared: assert property (coreShared && anyAccess && upperCtr |=> protectionFault)
    else $error("upper counter reachable when shared");
  chk_upper_open: assert property (!coreShared && anyAccess && upperCtr |=> regDone)
    else $error("upper counter refused when not shared");
  chk_enable_fault: assert property (coreShared && regWrite && regAddr == 12'h38F
    && regWdata[7:4] != 4'h0 |=> protectionFault)
    else $error("upper enable set while shared");
  chk_count_four: assert property (coreShared [*2] |-> counterCount == 8'h04)
    else $error("count field not four");
  chk_count_eight: assert property ((!coreShared) [*2] |-> counterCount == 8'h08)
    else $error("count field not eight");
  chk_status_readonly: assert property (regWrite && regAddr == 12'h38E |=> protectionFault)
    else $error("status write accepted");
  chk_store_bounds: assert property ($rose(recordStore) |-> $past(boundsOk, 2))
    else $error("record stored after failed bounds check");
  chk_store_pulse: assert property (recordStore |=> !recordStore)
    else $error("record pulse too long");
endmodule // pcgc_global_ctrl_properties

bind pcgc_global_ctrl pcgc_global_ctrl_properties #(.WIDTH(WIDTH), .NGEN(NGEN), .NFIX(NFIX))
  pcgc_global_ctrl_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n), .coreShared(coreShared),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .boundsOk(boundsOk), .regDone(regDone), .protectionFault(protectionFault),
  .recordStore(recordStore), .counterCount(counterCount));

// ### tb/pcgc_global_ctrl_tb_top.sv
// Self-checking bench for the counter global control block.
`timescale 1ns/1ps
module pcgc_global_ctrl_tb_top;
  // ==========================================================
  // Stimulus, responses and bookkeeping.
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg coreShared = 1'b0;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg [11:0] regAddr = 12'h000;
  reg [63:0] regWdata = 64'h0;
  reg privUser = 1'b0;
  reg [7:0] genEvent = 8'h00;
  reg [2:0] fixEvent = 3'h0;
  reg [3:0] preciseEnable = 4'h0;
  reg [47:0] reloadValue = 48'h0;
  reg boundsOk = 1'b0;
  reg bufferFull = 1'b0;
  wire [63:0] regRdata;
  wire regDone;
  wire protectionFault;
  wire recordStore;
  wire [1:0] recordCounter;
  wire [7:0] counterCount;
  integer bad_count = 0;
  integer checks_done = 0;
  integer stores;
  integer i;
  // Row: shared, write, address, data, read mask, expected read, expected fault.
  typedef struct packed {logic sh; logic wr; logic [11:0] a; logic [63:0] d;
    logic [63:0] m; logic [63:0] e; logic f;} pcgc_row_t;
  pcgc_row_t rows [0:15];
  localparam [63:0] C48 = 64'hFFFF_FFFF_FFFF; // Counter width mask.
  always #2.5 ref_clk = ~ref_clk;
  pcgc_global_ctrl pcgc_global_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .coreShared(coreShared), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .privUser(privUser), .genEvent(genEvent), .fixEvent(fixEvent),
    .preciseEnable(preciseEnable), .reloadValue(reloadValue), .boundsOk(boundsOk),
    .bufferFull(bufferFull), .regRdata(regRdata), .regDone(regDone),
    .protectionFault(protectionFault), .recordStore(recordStore),
    .recordCounter(recordCounter), .counterCount(counterCount));
  // ==========================================================
  // Shared tasks.
  // Compares one value and counts the outcome.
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // One register access; the answer is looked at in its one-cycle window.
  task acc(input logic wr, input logic [11:0] a, input logic [63:0] d);
    begin
      @(posedge ref_clk);
      #1;
      regWrite = wr;
      regRead = !wr;
      regAddr = a;
      regWdata = d;
      @(posedge ref_clk);
      #1;
      regWrite = 1'b0;
      regRead = 1'b0;
    end
  endtask
  // Read that must succeed, with masked data compare.
  task rdchk(input logic [11:0] a, input logic [63:0] m, input logic [63:0] e);
    begin
      acc(1'b0, a, 64'h0);
      cmp({protectionFault, regDone}, 64'h1);
      cmp(regRdata & m, e);
    end
  endtask
  // One-cycle event pulse on the general counters.
  task ev(input logic [7:0] e);
    begin
      @(posedge ref_clk);
      #1;
      genEvent = e;
      @(posedge ref_clk);
      #1;
      genEvent = 8'h00;
    end
  endtask
  // Wraps counter zero, sends the sampling event and counts record pulses.
  task sam(input logic ok);
    begin
      boundsOk = ok;
      acc(1'b1, 12'h4C1, C48);
      ev(8'h01);
      ev(8'h01);
      stores = 0;
      repeat (8) begin
        @(posedge ref_clk);
        #1;
        if (recordStore === 1'b1) begin
          stores = stores + 1;
          cmp(recordCounter, 64'h0);
        end
      end
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task complete_run;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    #20000;
    bad_count = bad_count + 1;
    complete_run;
  end
  // ==========================================================
  // Main sequence.
  initial begin
    rows[0] = '{1'b0, 1'b1, 12'h345, 64'h0, 64'h0, 64'h0, 1'b1};
    rows[1] = '{1'b0, 1'b0, 12'h345, 64'h0, 64'h2000, 64'h2000, 1'b0};
    rows[2] = '{1'b0, 1'b1, 12'h0C1, 64'h8000_0000, 64'h0, 64'h0, 1'b0};
    rows[3] = '{1'b0, 1'b0, 12'h0C1, 64'h0, C48, 64'hFFFF_8000_0000, 1'b0};
    rows[4] = '{1'b0, 1'b1, 12'h4C1, 64'h1234_5678_9ABC, 64'h0, 64'h0, 1'b0};
    rows[5] = '{1'b0, 1'b0, 12'h0C1, 64'h0, C48, 64'h1234_5678_9ABC, 1'b0};
    rows[6] = '{1'b0, 1'b1, 12'h0C8, 64'h5, 64'h0, 64'h0, 1'b0};
    rows[7] = '{1'b0, 1'b0, 12'h0C8, 64'h0, C48, 64'h5, 1'b0};
    rows[8] = '{1'b0, 1'b1, 12'h38F, 64'hF0, 64'h0, 64'h0, 1'b0};
    rows[9] = '{1'b0, 1'b0, 12'h38F, 64'h0, 64'hFF, 64'hF0, 1'b0};
    rows[10] = '{1'b1, 1'b0, 12'h0C5, 64'h0, 64'h0, 64'h0, 1'b1};
    rows[11] = '{1'b1, 1'b1, 12'h38F, 64'h10, 64'h0, 64'h0, 1'b1};
    rows[12] = '{1'b1, 1'b1, 12'h390, 64'h80, 64'h0, 64'h0, 1'b1};
    rows[13] = '{1'b1, 1'b1, 12'h4C8, 64'h1, 64'h0, 64'h0, 1'b1};
    rows[14] = '{1'b0, 1'b1, 12'h38E, 64'h1, 64'h0, 64'h0, 1'b1};
    rows[15] = '{1'b0, 1'b0, 12'h390, 64'h0, 64'h0, 64'h0, 1'b1};
    repeat (10) @(posedge ref_clk);
    #1;
    cmp(counterCount, 64'h4);
    rst_n = 1'b1;
    rdchk(12'h38E, {64{1'b1}}, 64'h0);
    rdchk(12'h38F, {64{1'b1}}, 64'h0);
    for (i = 0; i < 16; i = i + 1) begin
      coreShared = rows[i].sh;
      repeat (2) @(posedge ref_clk);
      #1;
      cmp(counterCount, rows[i].sh ? 64'h4 : 64'h8);
      acc(rows[i].wr, rows[i].a, rows[i].d);
      cmp({protectionFault, regDone}, {rows[i].f, !rows[i].f});
      if (!rows[i].wr && !rows[i].f) cmp(regRdata & rows[i].m, rows[i].e);
    end
    // Privilege and global enable gating on counter zero.
    coreShared = 1'b0;
    // The condition-changed flag is cleared first so that the enable write must set it again.
    acc(1'b1, 12'h390, 64'h8000_0000_0000_0000);
    rdchk(12'h38E, 64'h8000_0000_0000_0000, 64'h0);
    acc(1'b1, 12'h186, 64'h0042_0000);
    acc(1'b1, 12'h0C1, 64'h0);
    acc(1'b1, 12'h38F, 64'h1);
    rdchk(12'h38E, 64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000);
    privUser = 1'b1;
    ev(8'h01);
    rdchk(12'h0C1, C48, 64'h0);
    privUser = 1'b0;
    ev(8'h01);
    rdchk(12'h0C1, C48, 64'h1);
    acc(1'b1, 12'h38F, 64'h0);
    ev(8'h01);
    rdchk(12'h0C1, C48, 64'h1);
    // Fixed counter control keeps only its twelve implemented bits.
    acc(1'b1, 12'h38D, 64'h0000_0000_0001_FA53);
    rdchk(12'h38D, {64{1'b1}}, 64'h0000_0000_0000_0A53);
    // Precise sampling with passing, then failing, bounds checks.
    acc(1'b1, 12'h186, 64'h0043_0000);
    acc(1'b1, 12'h38F, 64'h1);
    preciseEnable = 4'h1;
    reloadValue = 48'h100;
    sam(1'b1);
    cmp(stores, 64'h1);
    rdchk(12'h0C1, C48, 64'h100);
    rdchk(12'h38E, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000);
    sam(1'b0);
    cmp(stores, 64'h0);
    rdchk(12'h0C1, C48, 64'h1);
    rdchk(12'h38E, 64'hA000_0000_0000_0001, 64'hA000_0000_0000_0001);
    // Selected clear, then buffer-full status.
    acc(1'b1, 12'h390, 64'h1);
    rdchk(12'h38E, 64'h1, 64'h0);
    @(posedge ref_clk);
    #1;
    bufferFull = 1'b1;
    @(posedge ref_clk);
    #1;
    bufferFull = 1'b0;
    rdchk(12'h38E, 64'h4000_0000_0000_0000, 64'h4000_0000_0000_0000);
    // Reset in mid-run clears the registers and reports four counters again.
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    cmp(counterCount, 64'h4);
    cmp(regRdata, 64'h0);
    rst_n = 1'b1;
    rdchk(12'h38F, {64{1'b1}}, 64'h0);
    rdchk(12'h38E, {64{1'b1}}, 64'h0);
    complete_run;
  end
endmodule // pcgc_global_ctrl_tb_top
